// file: nfr_pkg.sv
// Constants and field layout of the front end register group
`default_nettype none

package nfr_pkg;

	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int ADDR_W    = 12;
	localparam int DATA_W    = 32;
	localparam int SPACE_BIT = 10;
	localparam int HIGH_BIT  = 11;

	// ----------------------------------------
	// Register indexes (byte address = 4 x index, plus 0x400 for OVHI and OVLO)
	// ----------------------------------------
	localparam logic [7:0] IDX_GAIN     = 8'h2E;
	localparam logic [7:0] IDX_CSCTL    = 8'h2F;
	localparam logic [7:0] IDX_CSDISP   = 8'h30;
	localparam logic [7:0] IDX_AUX      = 8'h31;
	localparam logic [7:0] IDX_OVHI     = 8'h30;
	localparam logic [7:0] IDX_OVLO     = 8'h31;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h3E;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h3F;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] CSCTL_RST = 8'h00;
	localparam logic [7:0] OVHI_RST  = 8'h00;
	localparam logic [7:0] OVLO_RST  = 8'h00;
	localparam logic [3:0] MASK_RST  = 4'h0;

	// ----------------------------------------
	// Field positions and widths
	// ----------------------------------------
	localparam int GAIN_W   = 4;
	localparam int CAL_W    = 5;
	localparam int SGAIN_W  = 3;
	localparam int PAT_W    = 14;
	localparam int PAT_HI_W = 6;
	localparam int EV_N     = 4;
	localparam int CAL_LSB  = 3;
	localparam int DISP_END = 2;
	localparam int DISP_ERR = 1;
	localparam int AUX_CHA  = 7;
	localparam int AUX_EFD  = 6;
	localparam int AUX_TX   = 5;
	localparam int AUX_OSC  = 4;
	localparam int AUX_RXON = 3;
	localparam int AUX_RXA  = 2;
	localparam int AUX_PEER = 1;
	localparam int AUX_AVD  = 0;

	// ----------------------------------------
	// Interrupt event bits
	// ----------------------------------------
	localparam int EV_CAL_END = 0;
	localparam int EV_CAL_ERR = 1;
	localparam int EV_FIELD   = 2;
	localparam int EV_OSC_OK  = 3;

	// ----------------------------------------
	// Drive level codes
	// ----------------------------------------
	localparam logic [1:0] DRV_SUPPLY = 2'h0;
	localparam logic [1:0] DRV_MOD    = 2'h1;
	localparam logic [1:0] DRV_STOP   = 2'h2;
	localparam logic [1:0] DRV_RSVD   = 2'h3;

endpackage : nfr_pkg

`default_nettype wire

// file: nfr_regs.sv
// Front end status, sensor and overshoot register group on APB
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none


module nfr_regs (
	// Clock, enable and reset
	input  wire logic                        CLK_SYS_IN,
	input  wire logic                        CE_IN,
	input  wire logic                        ARST_N_IN,
	// APB slave
	input  wire logic                        PSEL_IN,
	input  wire logic                        PENABLE_IN,
	input  wire logic                        PWRITE_IN,
	input  wire logic [nfr_pkg::ADDR_W-1:0]  PADDR_IN,
	input  wire logic [nfr_pkg::DATA_W-1:0]  PWDATA_IN,
	output logic                             PREADY_OUT,
	output logic                             PSLVERR_OUT,
	output logic [nfr_pkg::DATA_W-1:0]       PRDATA_OUT,
	// Receiver state
	input  wire logic [nfr_pkg::GAIN_W-1:0]  AM_GAIN_CUT_STATE_IN,
	input  wire logic [nfr_pkg::GAIN_W-1:0]  PM_GAIN_CUT_STATE_IN,
	input  wire logic                        RX_CHANNEL_PM_IN,
	input  wire logic                        RX_ON_IN,
	input  wire logic                        RX_ACT_IN,
	// Field detector
	input  wire logic                        FIELD_DET_IN,
	input  wire logic                        PEER_MODE_IN,
	input  wire logic                        DETECTOR_AVOID_MODE_IN,
	// Transmitter and oscillator
	input  wire logic                        TX_ACTIVE_IN,
	input  wire logic                        TX_CA_AUTO_IN,
	input  wire logic                        OSC_RUN_IN,
	input  wire logic                        OSC_STABLE_IN,
	// Capacitive sensor
	input  wire logic [nfr_pkg::CAL_W-1:0]   CAL_VALUE_IN,
	input  wire logic                        CAL_END_IN,
	input  wire logic                        CAL_ERR_IN,
	output logic [nfr_pkg::CAL_W-1:0]        CAP_MCAL_OUT,
	output logic                             CAP_AUTO_CAL_OUT,
	output logic [nfr_pkg::SGAIN_W-1:0]      CAP_GAIN_OUT,
	// Overshoot protection
	output logic [1:0]                       OVERSHOOT_DRIVE_LEVEL_OUT,
	output logic [nfr_pkg::PAT_W-1:0]        OVERSHOOT_DRIVE_PATTERN_OUT,
	// Interrupt
	output logic                             IRQ_OUT
);
	import nfr_pkg::*;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0]      gain_reg;
	logic [7:0]      csdisp_reg;
	logic [7:0]      aux_reg;
	logic [7:0]      csctl_reg;
	logic            auto_cal_reg;
	logic [7:0]      ovhi_reg;
	logic [7:0]      ovlo_reg;
	logic [EV_N-1:0] stat_reg;
	logic [EV_N-1:0] stat_next;
	logic [EV_N-1:0] mask_reg;
	logic [EV_N-1:0] mask_next;
	logic [EV_N-1:0] ev;
	logic            irq_reg;
	logic            pready_reg;
	logic            pslverr_reg;
	logic [31:0]     prdata_reg;
	logic [7:0]      aux_next;
	logic [7:0]      csdisp_next;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic       setup;
	logic       wr;
	logic       sp_b;
	logic [7:0] idx;
	logic       hit;
	logic [7:0] rd;
	logic       sel_csctl;
	logic       sel_ovhi;
	logic       sel_ovlo;
	logic       sel_stat;
	logic       sel_mask;
	logic       sel_ro;

	assign setup = PSEL_IN && !PENABLE_IN;
	assign wr    = PSEL_IN && PENABLE_IN && pready_reg && PWRITE_IN;
	assign sp_b  = PADDR_IN[SPACE_BIT];
	assign idx   = PADDR_IN[9:2];

	always_comb begin
		hit       = 1'b0;
		rd        = 8'h00;
		sel_csctl = 1'b0;
		sel_ovhi  = 1'b0;
		sel_ovlo  = 1'b0;
		sel_stat  = 1'b0;
		sel_mask  = 1'b0;
		sel_ro    = 1'b0;
		if (PADDR_IN[1:0] == 2'h0 && !PADDR_IN[HIGH_BIT]) begin
			if (!sp_b) begin
				case (idx)
					IDX_GAIN: begin
						hit    = 1'b1;
						sel_ro = 1'b1;
						rd     = gain_reg;
					end
					IDX_CSCTL: begin
						hit       = 1'b1;
						sel_csctl = 1'b1;
						rd        = csctl_reg;
					end
					IDX_CSDISP: begin
						hit    = 1'b1;
						sel_ro = 1'b1;
						rd     = csdisp_reg;
					end
					IDX_AUX: begin
						hit    = 1'b1;
						sel_ro = 1'b1;
						rd     = aux_reg;
					end
					IDX_IRQ_STAT: begin
						hit      = 1'b1;
						sel_stat = 1'b1;
						rd       = {4'h0, stat_reg};
					end
					IDX_IRQ_MASK: begin
						hit      = 1'b1;
						sel_mask = 1'b1;
						rd       = {4'h0, mask_reg};
					end
					default: begin
						hit = 1'b0;
					end
				endcase
			end else begin
				case (idx)
					IDX_OVHI: begin
						hit      = 1'b1;
						sel_ovhi = 1'b1;
						rd       = ovhi_reg;
					end
					IDX_OVLO: begin
						hit      = 1'b1;
						sel_ovlo = 1'b1;
						rd       = ovlo_reg;
					end
					default: begin
						hit = 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// APB answer: one access cycle, no wait
	// ----------------------------------------
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end else if (CE_IN) begin
			pready_reg  <= setup;
			pslverr_reg <= setup && !hit;
			if (setup && !PWRITE_IN) begin
				prdata_reg <= {24'h000000, rd};
			end else begin
				prdata_reg <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// Read-only status capture
	// ----------------------------------------
	assign csdisp_next = {CAL_VALUE_IN, CAL_END_IN, CAL_ERR_IN, 1'b0};
	assign aux_next = {RX_CHANNEL_PM_IN,
		FIELD_DET_IN,
		TX_ACTIVE_IN && !TX_CA_AUTO_IN,
		OSC_RUN_IN && OSC_STABLE_IN,
		RX_ON_IN, RX_ACT_IN,
		PEER_MODE_IN, DETECTOR_AVOID_MODE_IN};

	// Bus writes never reach these, so readback follows the inputs only
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			gain_reg   <= 8'h00;
			csdisp_reg <= 8'h00;
			aux_reg    <= 8'h00;
		end else if (CE_IN) begin
			gain_reg   <= {AM_GAIN_CUT_STATE_IN, PM_GAIN_CUT_STATE_IN};
			csdisp_reg <= csdisp_next;
			aux_reg    <= aux_next;
		end
	end

	// ----------------------------------------
	// Sensor control
	// ----------------------------------------
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			csctl_reg    <= CSCTL_RST;
			auto_cal_reg <= 1'b1;
		end else if (CE_IN && wr && sel_csctl) begin
			csctl_reg    <= PWDATA_IN[7:0];
			auto_cal_reg <= (PWDATA_IN[7:CAL_LSB] == 5'h00);
		end
	end

	// ----------------------------------------
	// Overshoot protection
	// ----------------------------------------
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ovhi_reg <= OVHI_RST;
			ovlo_reg <= OVLO_RST;
		end else if (CE_IN && wr) begin
			if (sel_ovhi) begin
				ovhi_reg <= PWDATA_IN[7:0];
			end
			if (sel_ovlo) begin
				ovlo_reg <= PWDATA_IN[7:0];
			end
		end
	end

	// ----------------------------------------
	// Interrupts: rising edges of status, set beats clear
	// ----------------------------------------
	assign ev[EV_CAL_END] = csdisp_next[DISP_END] && !csdisp_reg[DISP_END];
	assign ev[EV_CAL_ERR] = csdisp_next[DISP_ERR] && !csdisp_reg[DISP_ERR];
	assign ev[EV_FIELD]   = aux_next[AUX_EFD] && !aux_reg[AUX_EFD];
	assign ev[EV_OSC_OK]  = aux_next[AUX_OSC] && !aux_reg[AUX_OSC];

	always_comb begin
		stat_next = stat_reg | ev;
		mask_next = mask_reg;
		if (wr && sel_stat) begin
			stat_next = (stat_reg & ~PWDATA_IN[EV_N-1:0]) | ev;
		end
		if (wr && sel_mask) begin
			mask_next = PWDATA_IN[EV_N-1:0];
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			stat_reg <= 4'h0;
			mask_reg <= MASK_RST;
			irq_reg  <= 1'b0;
		end else if (CE_IN) begin
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			irq_reg  <= |(stat_next & mask_next);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign PREADY_OUT                  = pready_reg;
	assign PSLVERR_OUT                 = pslverr_reg;
	assign PRDATA_OUT                  = prdata_reg;
	assign CAP_MCAL_OUT                = csctl_reg[7:CAL_LSB];
	assign CAP_AUTO_CAL_OUT            = auto_cal_reg;
	assign CAP_GAIN_OUT                = csctl_reg[SGAIN_W-1:0];
	assign OVERSHOOT_DRIVE_LEVEL_OUT   = ovhi_reg[7:6];
	assign OVERSHOOT_DRIVE_PATTERN_OUT = {ovhi_reg[PAT_HI_W-1:0], ovlo_reg};
	assign IRQ_OUT                     = irq_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (!ARST_N_IN);

	a_gain_am_view: assert property (
		CE_IN && ARST_N_IN |=> gain_reg[7:4] == $past(AM_GAIN_CUT_STATE_IN))
		else $error("AM gain cut readback wrong");

	a_gain_pm_view: assert property (
		CE_IN && ARST_N_IN |=> gain_reg[3:0] == $past(PM_GAIN_CUT_STATE_IN))
		else $error("PM gain cut readback wrong");

	a_mcal_write: assert property (
		CE_IN && wr && sel_csctl |=> CAP_MCAL_OUT == $past(PWDATA_IN[7:3]))
		else $error("manual calibration not stored");

	a_auto_cal_mode: assert property (
		CAP_AUTO_CAL_OUT == (CAP_MCAL_OUT == 5'h00))
		else $error("auto calibration flag mismatch");

	a_cal_display: assert property (
		CE_IN && ARST_N_IN |=> csdisp_reg[7:3] == $past(CAL_VALUE_IN))
		else $error("calibration display wrong");

	a_cal_flags: assert property (
		CE_IN && ARST_N_IN |=> csdisp_reg[2:0] ==
			{$past(CAL_END_IN), $past(CAL_ERR_IN), 1'b0})
		else $error("calibration flags wrong");

	a_aux_channel: assert property (
		CE_IN && ARST_N_IN |=> aux_reg[AUX_CHA] == $past(RX_CHANNEL_PM_IN))
		else $error("channel bit wrong");

	a_aux_field: assert property (
		CE_IN && ARST_N_IN && FIELD_DET_IN |=> aux_reg[AUX_EFD])
		else $error("field detect not shown");

	a_tx_flag: assert property (
		CE_IN && TX_CA_AUTO_IN |=> !aux_reg[AUX_TX])
		else $error("avoidance transmission flagged");

	a_osc_ok: assert property (
		CE_IN && !(OSC_RUN_IN && OSC_STABLE_IN) |=> !aux_reg[AUX_OSC])
		else $error("oscillator flagged while not stable");

	a_rx_flags: assert property (
		CE_IN && ARST_N_IN |=> aux_reg[3:2] == {$past(RX_ON_IN), $past(RX_ACT_IN)})
		else $error("decoder flags wrong");

	a_det_modes: assert property (
		CE_IN && ARST_N_IN |=> aux_reg[1:0] ==
			{$past(PEER_MODE_IN), $past(DETECTOR_AVOID_MODE_IN)})
		else $error("detector mode flags wrong");

	a_drive_level: assert property (
		CE_IN && wr && sel_ovhi |=>
			OVERSHOOT_DRIVE_LEVEL_OUT == $past(PWDATA_IN[7:6]))
		else $error("drive level not stored");

	a_pattern_lo: assert property (
		CE_IN && wr && sel_ovlo |=>
			OVERSHOOT_DRIVE_PATTERN_OUT[7:0] == $past(PWDATA_IN[7:0]))
		else $error("pattern low byte not stored");

	a_ro_ignored: assert property (
		wr && sel_ro |=> $stable(csctl_reg) && $stable(ovhi_reg)
			&& $stable(ovlo_reg))
		else $error("read-only write disturbed state");

	a_irq_level: assert property (
		CE_IN |=> IRQ_OUT == |(stat_reg & mask_reg))
		else $error("interrupt level wrong");

	a_apb_answer: assert property (
		CE_IN && setup ##1 CE_IN && PSEL_IN && PENABLE_IN |-> PREADY_OUT)
		else $error("no answer in access cycle");

endmodule : nfr_regs

`default_nettype wire

// file: nfr_tb.sv
// Self-checking testbench for the front end register group
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module testbench;
	import nfr_pkg::*;

	typedef struct packed {
		logic [7:0] gain;
		logic [6:0] cal;
		logic [9:0] flg;
		logic [7:0] disp;
		logic [7:0] aux;
	} nfr_row_t;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic              clk, ce, rst_n, psel, penable, pwrite, pready, pslverr, irq;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [3:0]        am, pm;
	logic [4:0]        calv, mcal;
	logic              cend, cerr, cha, efd, tx, txca, orun, ostb, rxon, rxact, peer, avd;
	logic              auto_cal, er;
	logic [2:0]        cgain;
	logic [1:0]        lvl;
	logic [13:0]       pat;
	int                mismatches = 0;
	int                compares = 0;
	logic [11:0]       ro_a [3] = '{12'h0B8, 12'h0C0, 12'h0C4};
	logic [7:0]        ro_v [3] = '{8'h0F, 8'h00, 8'h49};
	// Flags: cha efd tx txca osc_run osc_stable rx_on rx_act peer avoid
	nfr_row_t          rows [4] = '{
		'{8'hA5, 7'h7F, 10'h3BF, 8'hFE, 8'hFF},
		'{8'h3C, 7'h05, 10'h0E0, 8'h0A, 8'h00},
		'{8'hF0, 7'h42, 10'h212, 8'h84, 8'h82},
		'{8'h0F, 7'h00, 10'h109, 8'h00, 8'h49}};

	nfr_regs uut (
		.CLK_SYS_IN(clk), .CE_IN(ce), .ARST_N_IN(rst_n),
		.PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .PRDATA_OUT(prdata),
		.AM_GAIN_CUT_STATE_IN(am), .PM_GAIN_CUT_STATE_IN(pm),
		.RX_CHANNEL_PM_IN(cha), .RX_ON_IN(rxon), .RX_ACT_IN(rxact),
		.FIELD_DET_IN(efd), .PEER_MODE_IN(peer), .DETECTOR_AVOID_MODE_IN(avd),
		.TX_ACTIVE_IN(tx), .TX_CA_AUTO_IN(txca), .OSC_RUN_IN(orun), .OSC_STABLE_IN(ostb),
		.CAL_VALUE_IN(calv), .CAL_END_IN(cend), .CAL_ERR_IN(cerr),
		.CAP_MCAL_OUT(mcal), .CAP_AUTO_CAL_OUT(auto_cal), .CAP_GAIN_OUT(cgain),
		.OVERSHOOT_DRIVE_LEVEL_OUT(lvl), .OVERSHOOT_DRIVE_PATTERN_OUT(pat), .IRQ_OUT(irq)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, pready, 1'b1);
		end
	endtask : apb

	task automatic rchk(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, {24'h0, e})
		`CHK(er, 1'b0)
	endtask : rchk

	task automatic tally_and_finish();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{ce, rst_n, psel, penable, pwrite, paddr, pwdata} = {1'b1, 1'b0, 47'h0};
		{am, pm, calv, cend, cerr} = '0;
		{cha, efd, tx, txca, orun, ostb, rxon, rxact, peer, avd} = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			@(posedge clk);
			{am, pm} <= rows[i].gain;
			{calv, cend, cerr} <= rows[i].cal;
			{cha, efd, tx, txca, orun, ostb, rxon, rxact, peer, avd} <= rows[i].flg;
			repeat (2) @(posedge clk);
			rchk(12'h0B8, rows[i].gain);
			rchk(12'h0C0, rows[i].disp);
			rchk(12'h0C4, rows[i].aux);
		end
		$display("test status rows done");
		apb(1'b1, 12'h0BC, 32'hFFFF_FF08);
		@(posedge clk);
		`CHK(mcal, 5'h01)
		`CHK(auto_cal, 1'b0)
		apb(1'b1, 12'h0BC, 32'h0000_00FD);
		@(posedge clk);
		`CHK(mcal, 5'h1F)
		`CHK(cgain, 3'h5)
		rchk(12'h0BC, 8'hFD);
		apb(1'b1, 12'h0BC, 32'h0000_0007);
		@(posedge clk);
		`CHK(auto_cal, 1'b1)
		`CHK(mcal, 5'h00)
		$display("test sensor control done");
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, 12'h4C0, {24'h0, c[1:0], 6'h2A});
			apb(1'b1, 12'h4C4, 32'h5C ^ c);
			@(posedge clk);
			`CHK(lvl, c[1:0])
			`CHK(pat, {6'h2A, 8'h5C ^ c[7:0]})
			rchk(12'h4C0, {c[1:0], 6'h2A});
		end
		$display("test overshoot done");
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, ro_a[k], 32'h0000_00FF);
			`CHK(er, 1'b0)
			rchk(ro_a[k], ro_v[k]);
		end
		rchk(12'h4C0, 8'hEA);
		apb(1'b0, 12'h200, 32'h0);
		`CHK(er, 1'b1)
		`CHK(rd, 32'h0)
		apb(1'b1, 12'h8BC, 32'h0000_00F8);
		`CHK(er, 1'b1)
		rchk(12'h0BC, 8'h07);
		$display("test read-only and unmapped done");
		@(posedge clk);
		{cha, efd, tx, txca, orun, ostb, rxon, rxact, peer, avd} <= '0;
		{calv, cend, cerr} <= '0;
		repeat (3) @(posedge clk);
		apb(1'b1, 12'h0F8, 32'h0000_000F);
		rchk(12'h0F8, 8'h00);
		apb(1'b1, 12'h0FC, 32'h0000_0004);
		efd <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK(irq, 1'b1)
		rchk(12'h0F8, 8'h04);
		rchk(12'h0C4, 8'h40);
		apb(1'b1, 12'h0FC, 32'h0);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		apb(1'b1, 12'h0FC, 32'h0000_0004);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		apb(1'b1, 12'h0F8, 32'h0000_0004);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		ce  <= 1'b0;
		efd <= 1'b0;
		@(posedge clk);
		efd <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK(irq, 1'b0)
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		$display("test interrupt done");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK(auto_cal, 1'b1)
		`CHK(lvl, 2'h0)
		`CHK(pat, 14'h0)
		`CHK(irq, 1'b0)
		rst_n <= 1'b1;
		rchk(12'h0BC, 8'h00);
		rchk(12'h4C0, 8'h00);
		rchk(12'h4C4, 8'h00);
		rchk(12'h0FC, 8'h00);
		$display("test second reset done");
		tally_and_finish();
	end

endmodule : testbench

`default_nettype wire
